/* hw/bmc_pkg.sv */
package bmc_pkg;

  // bus and timing
  localparam int unsigned APB_ADDR_W       = 12;
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned SW_RESET_TIME_NS = 1000;
  localparam int unsigned SW_RESET_CYCLES  =
    (SW_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte addresses
  localparam logic [APB_ADDR_W-1:0] ADDR_CONTROL = 12'h000;
  localparam logic [APB_ADDR_W-1:0] ADDR_STATUS  = 12'h004;

  // control word field positions
  localparam int unsigned BIT_RESET      = 15;
  localparam int unsigned BIT_LOOPBACK   = 14;
  localparam int unsigned BIT_SPEED      = 13;
  localparam int unsigned BIT_AUTONEG    = 12;
  localparam int unsigned BIT_POWER_DOWN = 11;
  localparam int unsigned BIT_ISOLATE    = 10;
  localparam int unsigned BIT_DUPLEX     = 8;

  // status word field positions
  localparam int unsigned ST_LINK_BIT  = 2;
  localparam int unsigned ST_FAULT_BIT = 4;
  localparam int unsigned ST_PERM_LSB  = 5;
  localparam int unsigned ST_PERM_W    = 3;
  localparam int unsigned ST_CNT_LSB   = 8;
  localparam int unsigned ST_CNT_W     = 8;

  // reset values
  localparam logic [ST_PERM_W-1:0] ST_PERM_VALUE  = 3'h5;
  localparam logic                 LINK_RESET     = 1'h0;
  localparam logic                 FAULT_RESET    = 1'h0;
  localparam logic [ST_CNT_W-1:0]  CNT_RESET      = 8'h00;
  localparam logic [3:0]           PIN_SYNC_RESET = 4'h8;

  typedef enum logic [1:0] {
    FK_LATCHED_LOW   = 2'b00,
    FK_LATCHED_HIGH  = 2'b01,
    FK_CLEAR_ON_READ = 2'b10
  } bmc_field_kind_t;

  typedef struct packed {
    logic speed100;
    logic autoNegEn;
    logic fullDuplex;
  } bmc_strap_t;

  typedef struct packed {
    logic loopback;
    logic speed100;
    logic autoNegEn;
    logic powerDown;
    logic isolate;
    logic fullDuplex;
  } bmc_ctrl_t;

  localparam bmc_ctrl_t CTRL_RESET = 6'h00;

  typedef struct packed {
    logic [3:0] data;
    logic       en;
    logic       er;
  } bmc_mii_t;

  localparam bmc_mii_t MII_IDLE = 6'h00;

endpackage

/* hw/bmc_latch_field.sv */
`timescale 1ns/10ps
`default_nettype none

module bmc_latch_field
  import bmc_pkg::*;
#(
  parameter int unsigned     WIDTH       = 1,
  parameter bmc_field_kind_t KIND        = FK_LATCHED_HIGH,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             cond,
  input  wire logic             readClear,
  output logic [WIDTH-1:0]      value
);

  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;
  logic [WIDTH-1:0] base;

  // the read reloads from the live condition, so an event in the read cycle survives
  assign base = readClear ? ((KIND == FK_LATCHED_LOW) ? {WIDTH{1'b1}} : '0) : value_reg;

  always_comb begin
    case (KIND)
      FK_LATCHED_LOW:  value_next = base & {WIDTH{cond}};
      FK_LATCHED_HIGH: value_next = base | {WIDTH{cond}};
      default: begin
        // saturating count, emptied by each read
        value_next = (cond && (base != {WIDTH{1'b1}})) ? base + 1'b1 : base;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

`default_nettype wire

/* hw/bmc_reset_seq.sv */
`timescale 1ns/10ps
`default_nettype none

module bmc_reset_seq
  import bmc_pkg::*;
#(
  parameter int unsigned CYCLES = SW_RESET_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      strapLoad
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef enum logic {
    RS_IDLE = 1'b0,
    RS_BUSY = 1'b1
  } bmc_rs_state_t;

  bmc_rs_state_t state_reg;
  bmc_rs_state_t state_next;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      RS_IDLE: begin
        if (start) begin
          state_next = RS_BUSY;
          count_next = LAST;
        end
      end
      default: begin
        if (count_reg == '0) begin
          state_next = RS_IDLE;
        end else begin
          count_next = count_reg - 1'b1;
        end
      end
    endcase
  end

  // hardware reset also runs the sequence so strap synchronisers settle first
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= RS_BUSY;
      count_reg <= LAST;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign busy      = (state_reg == RS_BUSY);
  assign strapLoad = busy && (count_reg == '0);

endmodule

`default_nettype wire

/* hw/bmc_basic_mode_control.sv */
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module bmc_basic_mode_control
  import bmc_pkg::*;
#(
  parameter int unsigned         RESET_CYCLES = SW_RESET_CYCLES,
  parameter logic [ST_PERM_W-1:0] PERM_VALUE  = ST_PERM_VALUE
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  powerDownIrqPinN,
  input  wire bmc_strap_t            strapPins,
  input  wire logic                  anSpeed100,
  input  wire logic                  anFullDuplex,
  input  wire logic                  linkUp,
  input  wire logic                  remoteFault,
  input  wire logic                  rxErrorEvent,
  input  wire bmc_mii_t              miiTx,
  input  wire bmc_mii_t              lineRx,
  output bmc_mii_t                   miiRx,
  output bmc_mii_t                   lineTx,
  output logic                       speed100,
  output logic                       fullDuplex,
  output logic                       powerDown,
  output logic                       isolate,
  output logic                       loopback,
  output logic                       resetBusy
);

  // pin synchronisers: power-down pin and the three straps
  logic [3:0] pinRaw;
  logic [3:0] pinMeta_reg;
  logic [3:0] pinSync_reg;

  // pin resets to its idle level so no power-down is forced before the pin is seen
  assign pinRaw = {powerDownIrqPinN, strapPins};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          pinMeta_reg[gi] <= PIN_SYNC_RESET[gi];
          pinSync_reg[gi] <= PIN_SYNC_RESET[gi];
        end else begin
          pinMeta_reg[gi] <= pinRaw[gi];
          pinSync_reg[gi] <= pinMeta_reg[gi];
        end
      end
    end
  endgenerate

  bmc_strap_t strapNow;
  logic       pinPowerDown;

  assign strapNow     = pinSync_reg[2:0];
  assign pinPowerDown = ~pinSync_reg[3];

  // APB decode
  logic setupPhase;
  logic accessPhase;
  logic hitControl;
  logic hitStatus;
  logic unmapped;
  logic ctrlWrite;
  logic statusRead;
  logic readStrobe;

  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign readStrobe  = setupPhase && !pwrite;
  assign hitControl  = (paddr == ADDR_CONTROL);
  assign hitStatus   = (paddr == ADDR_STATUS);
  assign unmapped    = !hitControl && !hitStatus;
  assign ctrlWrite   = accessPhase && pwrite && hitControl;
  // read side effects at the setup edge, the same edge that captures prdata
  assign statusRead  = readStrobe && hitStatus;

  // zero wait states; the answer is always ready in the access phase
  assign pready  = 1'b1;
  assign pslverr = accessPhase && unmapped;

  // software reset sequencer
  logic swResetStart;
  logic busy;
  logic strapLoad;

  // writes are dropped while a reset is still running
  assign swResetStart = ctrlWrite && !busy && pwdata[BIT_RESET];

  bmc_reset_seq #(
    .CYCLES (RESET_CYCLES)
  ) u_reset_seq (
    .clk       (clk),
    .rst       (rst),
    .start     (swResetStart),
    .busy      (busy),
    .strapLoad (strapLoad)
  );

  // control register
  bmc_ctrl_t ctrl_reg;
  bmc_ctrl_t ctrl_next;
  bmc_ctrl_t ctrlWritten;
  bmc_ctrl_t ctrlStrapped;
  bmc_ctrl_t ctrlBase;
  logic      ctrlTake;

  assign ctrlTake = ctrlWrite && !busy && !pwdata[BIT_RESET];

  assign ctrlWritten.loopback   = pwdata[BIT_LOOPBACK];
  assign ctrlWritten.speed100   = pwdata[BIT_SPEED];
  assign ctrlWritten.autoNegEn  = pwdata[BIT_AUTONEG];
  assign ctrlWritten.powerDown  = pwdata[BIT_POWER_DOWN];
  assign ctrlWritten.isolate    = pwdata[BIT_ISOLATE];
  assign ctrlWritten.fullDuplex = pwdata[BIT_DUPLEX];

  // defaults as at power-up, with the strapped fields from the pins
  assign ctrlStrapped.loopback   = CTRL_RESET.loopback;
  assign ctrlStrapped.speed100   = strapNow.speed100;
  assign ctrlStrapped.autoNegEn  = strapNow.autoNegEn;
  assign ctrlStrapped.powerDown  = CTRL_RESET.powerDown;
  assign ctrlStrapped.isolate    = CTRL_RESET.isolate;
  assign ctrlStrapped.fullDuplex = strapNow.fullDuplex;

  // strap load ends every reset, hardware or software
  // writes are refused while busy, so a load and a take never meet
  assign ctrlBase = strapLoad ? ctrlStrapped :
                    ctrlTake  ? ctrlWritten  : ctrl_reg;

  always_comb begin
    ctrl_next = ctrlBase;
    // pin held low forces the bit; it wins over a software clear
    ctrl_next.powerDown = ctrlBase.powerDown || pinPowerDown;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // status fields
  logic                linkLatched;
  logic                faultLatched;
  logic [ST_CNT_W-1:0] errCount;

  bmc_latch_field #(
    .WIDTH       (1),
    .KIND        (FK_LATCHED_LOW),
    .RESET_VALUE (LINK_RESET)
  ) u_link_field (
    .clk       (clk),
    .rst       (rst),
    .cond      (linkUp),
    .readClear (statusRead),
    .value     (linkLatched)
  );

  bmc_latch_field #(
    .WIDTH       (1),
    .KIND        (FK_LATCHED_HIGH),
    .RESET_VALUE (FAULT_RESET)
  ) u_fault_field (
    .clk       (clk),
    .rst       (rst),
    .cond      (remoteFault),
    .readClear (statusRead),
    .value     (faultLatched)
  );

  bmc_latch_field #(
    .WIDTH       (ST_CNT_W),
    .KIND        (FK_CLEAR_ON_READ),
    .RESET_VALUE (CNT_RESET)
  ) u_err_count (
    .clk       (clk),
    .rst       (rst),
    .cond      (rxErrorEvent),
    .readClear (statusRead),
    .value     (errCount)
  );

  // read words; unused and reserved bits read zero
  logic [15:0] ctrlWord;
  logic [15:0] statusWord;
  logic [31:0] readMux;

  always_comb begin
    ctrlWord                 = 16'h0000;
    ctrlWord[BIT_RESET]      = busy;
    ctrlWord[BIT_LOOPBACK]   = ctrl_reg.loopback;
    ctrlWord[BIT_SPEED]      = ctrl_reg.speed100;
    ctrlWord[BIT_AUTONEG]    = ctrl_reg.autoNegEn;
    ctrlWord[BIT_POWER_DOWN] = ctrl_reg.powerDown;
    ctrlWord[BIT_ISOLATE]    = ctrl_reg.isolate;
    ctrlWord[BIT_DUPLEX]     = ctrl_reg.fullDuplex;
  end

  always_comb begin
    statusWord                          = 16'h0000;
    statusWord[ST_LINK_BIT]             = linkLatched;
    statusWord[ST_FAULT_BIT]            = faultLatched;
    statusWord[ST_PERM_LSB +: ST_PERM_W] = PERM_VALUE;
    statusWord[ST_CNT_LSB +: ST_CNT_W]   = errCount;
  end

  assign readMux = hitControl ? {16'h0000, ctrlWord}   :
                   hitStatus  ? {16'h0000, statusWord} : 32'h0000_0000;

  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  assign prdata_next = readStrobe ? readMux : prdata_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  // effective modes
  logic pdEff;
  logic isoEff;
  logic lbEff;
  logic spdEff;
  logic dupEff;

  assign pdEff  = ctrl_reg.powerDown || pinPowerDown;
  assign isoEff = ctrl_reg.isolate;
  assign lbEff  = ctrl_reg.loopback;
  // negotiated result wins while auto-negotiation is on
  assign spdEff = ctrl_reg.autoNegEn ? anSpeed100   : ctrl_reg.speed100;
  assign dupEff = ctrl_reg.autoNegEn ? anFullDuplex : ctrl_reg.fullDuplex;

  // MII datapath
  bmc_mii_t miiRx_reg;
  bmc_mii_t miiRx_next;
  bmc_mii_t lineTx_reg;
  bmc_mii_t lineTx_next;
  logic     pathDead;
  logic     rxQuiet;
  logic     txQuiet;

  // register block alone stays alive in power-down and during reset
  assign pathDead = pdEff || busy;

  // isolate parks the MII outputs; management above is untouched
  assign rxQuiet = pathDead || isoEff;
  // the line stays quiet in loopback so no frame leaks onto the cable
  assign txQuiet = rxQuiet || lbEff;

  assign miiRx_next = rxQuiet ? MII_IDLE :
                      lbEff   ? miiTx    :
                                lineRx;

  assign lineTx_next = txQuiet ? MII_IDLE : miiTx;

  always_ff @(posedge clk) begin
    if (rst) begin
      miiRx_reg  <= MII_IDLE;
      lineTx_reg <= MII_IDLE;
    end else begin
      miiRx_reg  <= miiRx_next;
      lineTx_reg <= lineTx_next;
    end
  end

  assign miiRx  = miiRx_reg;
  assign lineTx = lineTx_reg;

  // mode outputs, registered
  logic speed100_reg;
  logic fullDuplex_reg;
  logic powerDown_reg;
  logic isolate_reg;
  logic loopback_reg;
  logic resetBusy_reg;

  // rate outputs move on a register write, a strap load or a new negotiation result
  always_ff @(posedge clk) begin
    if (rst) begin
      speed100_reg   <= 1'b0;
      fullDuplex_reg <= 1'b0;
    end else begin
      speed100_reg   <= spdEff;
      fullDuplex_reg <= dupEff;
    end
  end

  // busy resets high so the far side sees the power-up sequence running
  always_ff @(posedge clk) begin
    if (rst) begin
      powerDown_reg  <= 1'b0;
      isolate_reg    <= 1'b0;
      loopback_reg   <= 1'b0;
      resetBusy_reg  <= 1'b1;
    end else begin
      powerDown_reg  <= pdEff;
      isolate_reg    <= isoEff;
      loopback_reg   <= lbEff;
      resetBusy_reg  <= busy;
    end
  end

  assign speed100   = speed100_reg;
  assign fullDuplex = fullDuplex_reg;
  assign powerDown  = powerDown_reg;
  assign isolate    = isolate_reg;
  assign loopback   = loopback_reg;
  assign resetBusy  = resetBusy_reg;

endmodule

`default_nettype wire

/* verif/bmc_ctrl_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module bmc_ctrl_checker
  import bmc_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = SW_RESET_CYCLES
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  powerDownIrqPinN,
  input wire bmc_mii_t              miiTx,
  input wire bmc_mii_t              lineRx,
  input wire bmc_mii_t              miiRx,
  input wire bmc_mii_t              lineTx,
  input wire logic                  powerDown,
  input wire logic                  isolate,
  input wire logic                  loopback,
  input wire logic                  resetBusy
);
  logic [15:0] busyCnt;
  logic        swRun;
  wire logic   acc = psel && penable;
  wire logic   unmapped = paddr != ADDR_CONTROL && paddr != ADDR_STATUS;
  wire logic   normal = !loopback && !powerDown && !isolate && !resetBusy;

  // run length only judged for software resets; power-up run overlaps rst
  always_ff @(posedge clk) begin
    if (rst) begin
      busyCnt <= 16'h0;
      swRun <= 1'b0;
    end else begin
      busyCnt <= resetBusy ? busyCnt + 16'h1 : 16'h0;
      if ($rose(resetBusy))
        swRun <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_loop_route: assert property (loopback && normal == 1'b0 && !powerDown && !isolate && !resetBusy
    |-> miiRx == $past(miiTx)) else $error("loopback data wrong");
  a_loop_quiet: assert property (loopback |-> lineTx == MII_IDLE) else $error("line busy in loopback");
  a_normal_path: assert property (normal |-> miiRx == $past(lineRx) && lineTx == $past(miiTx))
    else $error("normal path wrong");
  a_pd_silent: assert property (powerDown |-> miiRx == MII_IDLE && lineTx == MII_IDLE)
    else $error("powered down but active");
  a_iso_silent: assert property (isolate |-> miiRx == MII_IDLE && lineTx == MII_IDLE)
    else $error("isolated but active");
  a_pin_sets_pd: assert property ((!powerDownIrqPinN && !resetBusy) [*6] |-> powerDown)
    else $error("pin did not power down");
  a_unmapped_err: assert property (acc && unmapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && !unmapped |-> !pslverr && (pwrite || prdata[31:16] == 16'h0))
    else $error("mapped access wrong");
  a_zero_wait: assert property (acc |-> pready)
    else $error("access not answered at once");
  a_busy_reads: assert property (acc && !pwrite && paddr == ADDR_CONTROL |-> prdata[BIT_RESET] == resetBusy)
    else $error("reset bit not busy");
  a_busy_len: assert property ($fell(resetBusy) && swRun |-> busyCnt == 16'(RESET_CYCLES))
    else $error("reset run length wrong");
endmodule

bind bmc_basic_mode_control bmc_ctrl_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .powerDownIrqPinN(powerDownIrqPinN), .miiTx(miiTx),
  .lineRx(lineRx), .miiRx(miiRx), .lineTx(lineTx), .powerDown(powerDown), .isolate(isolate),
  .loopback(loopback), .resetBusy(resetBusy)
);
`default_nettype wire

/* verif/bmc_mac_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bmc_mac_model
  import bmc_pkg::*;
(
  input  wire logic clk,
  output bmc_mii_t  miiTx,
  output bmc_mii_t  lineRx
);
  logic [3:0] step = 4'h0;
  // fresh nibble every cycle so a stale or stuck path shows
  always @(posedge clk) step <= step + 4'h1;
  // never waits on receive data, so a loopback dead time costs nothing
  assign miiTx  = '{data: step, en: 1'b1, er: 1'b0};
  assign lineRx = '{data: ~step, en: 1'b1, er: step[0]};
endmodule
`default_nettype wire

/* verif/bmc_basic_mode_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module bmc_basic_mode_control_tb
  import bmc_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, pinN, anS, anD, linkUp, rFault, rxErr;
  logic        pready, pslverr, spd, dup, pd, iso, lb, busy, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  bmc_strap_t  straps;
  bmc_mii_t    miiTx, lineRx, miiRx, lineTx;
  int          mismatches, n_checks;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  bmc_mac_model mac (.clk(clk), .miiTx(miiTx), .lineRx(lineRx));

  bmc_basic_mode_control #(.RESET_CYCLES(4)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerDownIrqPinN(pinN), .strapPins(straps), .anSpeed100(anS), .anFullDuplex(anD),
    .linkUp(linkUp), .remoteFault(rFault), .rxErrorEvent(rxErr), .miiTx(miiTx),
    .lineRx(lineRx), .miiRx(miiRx), .lineTx(lineTx), .speed100(spd), .fullDuplex(dup),
    .powerDown(pd), .isolate(iso), .loopback(lb), .resetBusy(busy)
  );

  task tally_and_finish;
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    if (i == 20) begin
      mismatches++;
      tally_and_finish;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0);
    chk(rd, exp);
  endtask

  task wait_idle;
    int i;
    for (i = 0; i < 200 && busy !== 1'b0; i++)
      cyc(1);
    if (i == 200) begin
      mismatches++;
      tally_and_finish;
    end
  endtask

  task t_reset_defaults;
    rdchk(ADDR_CONTROL, 32'h8000);
    wait_idle;
    rdchk(ADDR_CONTROL, 32'h2100);
    chk(32'({spd, dup}), 32'h3);
  endtask

  task t_forced_mode;
    apb(1'b1, ADDR_CONTROL, 16'h0000);
    cyc(2);
    chk(32'({spd, dup}), 32'h0);
    apb(1'b1, ADDR_CONTROL, 16'h3000);
    cyc(2);
    chk(32'({spd, dup}), 32'h1);
    rdchk(ADDR_CONTROL, 32'h3000);
  endtask

  task t_loopback;
    apb(1'b1, ADDR_CONTROL, 16'h6000);
    cyc(2);
    chk(32'({lb, spd}), 32'h3);
    chk(32'(miiRx), 32'({miiTx.data - 4'h1, 2'b10}));
    chk(32'(lineTx), 32'h0);
  endtask

  task t_power_down;
    apb(1'b1, ADDR_CONTROL, 16'h0800);
    cyc(2);
    chk(32'({pd, miiRx, lineTx}), 32'h1000);
    @(posedge clk);
    pinN <= 1'b0;
    apb(1'b1, ADDR_CONTROL, 16'h0000);
    cyc(6);
    chk(32'(pd), 32'h1);
    rdchk(ADDR_CONTROL, 32'h0800);
    @(posedge clk);
    pinN <= 1'b1;
    cyc(4);
    apb(1'b1, ADDR_CONTROL, 16'h0000);
    cyc(2);
    chk(32'(pd), 32'h0);
  endtask

  task t_isolate;
    apb(1'b1, ADDR_CONTROL, 16'h0400);
    cyc(2);
    chk(32'({iso, miiRx, lineTx}), 32'h1000);
    rdchk(ADDR_CONTROL, 32'h0400);
  endtask

  task t_soft_reset;
    apb(1'b1, ADDR_CONTROL, 16'h4000);
    @(posedge clk);
    straps <= '{speed100: 1'b0, autoNegEn: 1'b1, fullDuplex: 1'b0};
    cyc(4);
    apb(1'b1, ADDR_CONTROL, 16'h8400);
    rdchk(ADDR_CONTROL, 32'hc000);
    wait_idle;
    rdchk(ADDR_CONTROL, 32'h1000);
    chk(32'(lb), 32'h0);
  endtask

  task t_status;
    apb(1'b1, ADDR_STATUS, 16'hffff);
    rdchk(ADDR_STATUS, 32'h00a0);
    rdchk(ADDR_STATUS, 32'h00a4);
    @(posedge clk);
    linkUp <= 1'b0;
    rFault <= 1'b1;
    rxErr <= 1'b1;
    @(posedge clk);
    linkUp <= 1'b1;
    rFault <= 1'b0;
    repeat (2) @(posedge clk);
    rxErr <= 1'b0;
    rdchk(ADDR_STATUS, 32'h03b0);
    rdchk(ADDR_STATUS, 32'h00a4);
  endtask

  task t_unmapped;
    apb(1'b1, 12'h008, 16'hffff);
    chk(32'(err), 32'h1);
    apb(1'b0, 12'h00c, 16'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    rdchk(ADDR_CONTROL, 32'h1000);
  endtask

  initial begin
    rst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    pinN <= 1'b1;
    anS <= 1'b0;
    anD <= 1'b1;
    linkUp <= 1'b1;
    rFault <= 1'b0;
    rxErr <= 1'b0;
    straps <= '{speed100: 1'b1, autoNegEn: 1'b0, fullDuplex: 1'b1};
    mismatches = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset_defaults;
    t_forced_mode;
    t_loopback;
    t_power_down;
    t_isolate;
    t_soft_reset;
    t_status;
    t_unmapped;
    tally_and_finish;
  end
endmodule
`default_nettype wire
